// File: pci_master_burst_read_completion.sv
`timescale 1ns/10ps
// Overview of operation
// - Completed phase: word out next cycle if ready, count down
// - Strobe after trdy and ready both seen
// - Ready last cycle keeps irdy asserted
// - Final phase: frame released high, irdy held
// - Phase completes when irdy and trdy low
// - Last word delivered, count reaches zero
// - Turnaround: release frame, cbe; deassert irdy
// - Final phase done: termination, normal cause
// - Idle: release irdy, drop transfer strobe if read buffer empty
// - Start loads count from burst length
module pci_master_burst_read_completion
    import pci_burst_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               start_req,
    input  wire logic [BURST_W-1:0] burst_length,
    input  wire logic [DATA_W-1:0]  ad_in,
    input  wire logic               trdy_n,
    input  wire logic               local_ready_n,
    output logic                    frame_n,
    output logic                    frame_oe_n,
    output logic                    irdy_n,
    output logic                    irdy_oe_n,
    output logic [CBE_W-1:0]        cbe_n,
    output logic                    cbe_oe_n,
    output logic                    local_xfer_strobe_n,
    output logic [DATA_W-1:0]       local_data_out,
    output logic [BURST_W-1:0]      burst_remaining_count,
    output logic [STAT_W-1:0]       local_master_state,
    output logic [CAUSE_W-1:0]      end_cause
);
    // ========================================
    // State

    typedef struct packed {
        phase_t             phase;
        logic [BURST_W-1:0] count;
        logic               frame_n;
        logic               frame_oe_n;
        logic               irdy_n;
        logic               irdy_oe_n;
        logic               cbe_oe_n;
        logic               strobe_n;
        logic [DATA_W-1:0]  data;
        logic [STAT_W-1:0]  stat;
        logic [CAUSE_W-1:0] cause;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{
        phase:      PH_IDLE,
        count:      BURST_NIL,
        frame_n:    PIN_HI,
        frame_oe_n: OE_FLOAT,
        irdy_n:     PIN_HI,
        irdy_oe_n:  OE_FLOAT,
        cbe_oe_n:   OE_FLOAT,
        strobe_n:   PIN_HI,
        data:       DATA_NIL,
        stat:       STAT_IDLE,
        cause:      CAUSE_NONE
    };

    ctl_t               q;
    ctl_t               n;
    logic               done;
    logic               last;
    logic               irdy_next_n;
    logic [BURST_W-1:0] count_dec;

    word_fifo_if #(.W(DATA_W)) fq ();

    // ========================================
    // Read buffer

    // Every received word passes through the buffer; when it is empty and the
    // local master is ready it falls straight through without a wait.
    word_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_read_buf (
        .clk (mclk),
        .rst (sys_rst),
        .f   (fq)
    );

    // ========================================
    // Phase tracking

    // A data phase is complete in any cycle with irdy and trdy low.
    assign done = (q.phase == PH_DATA) && !q.irdy_n && !trdy_n;
    // A count of one means the phase in progress is the final one.
    assign last = q.count == BURST_ONE;
    assign count_dec = q.count - BURST_ONE;

    // The buffer room term holds irdy off rather than drop a word.
    assign irdy_next_n = local_ready_n || !fq.in_ready;

    // Buffer hookup: push on completion, drain while ready is low.
    assign fq.in_valid  = done;
    assign fq.in_data   = ad_in;
    assign fq.out_ready = !local_ready_n;

    // ========================================
    // Next state

    // All control decisions are taken here from the present state.
    always_comb
    begin
        n = q;
        // Hand-off: the word leaves with the strobe one cycle later.
        n.strobe_n = PIN_HI;
        if (fq.out_valid && fq.out_ready)
        begin
            n.data     = fq.out_data;
            n.strobe_n = PIN_LO;
        end
        unique case (q.phase)
            PH_IDLE:
            begin
                n.irdy_oe_n = OE_FLOAT;
                n.irdy_n    = PIN_HI;
                // A start is honoured only here; in data or turnaround
                // phases it is ignored, so a late pulse cannot restart.
                if (start_req)
                begin
                    n.phase      = PH_DATA;
                    n.count      = burst_length;
                    n.frame_oe_n = OE_DRIVE;
                    n.frame_n    = burst_length == BURST_ONE;
                    n.cbe_oe_n   = OE_DRIVE;
                    n.irdy_oe_n  = OE_DRIVE;
                    n.irdy_n     = irdy_next_n;
                    n.stat       = STAT_XACT;
                    n.cause      = CAUSE_NONE;
                end
            end
            PH_DATA:
            begin
                n.irdy_n = irdy_next_n;
                if (done)
                begin
                    n.count = count_dec;
                    // Next frame level looks one phase ahead.
                    n.frame_n = count_dec == BURST_ONE;
                    if (last)
                    begin
                        n.phase      = PH_TURN;
                        n.frame_n    = PIN_HI;
                        n.frame_oe_n = OE_FLOAT;
                        n.cbe_oe_n   = OE_FLOAT;
                        n.irdy_n     = PIN_HI;
                        n.stat       = STAT_TERM;
                        n.cause      = CAUSE_NORMAL;
                    end
                end
            end
            PH_TURN:
            begin
                // Irdy was driven high in turnaround, now let it float.
                n.phase     = PH_IDLE;
                n.irdy_oe_n = OE_FLOAT;
            end
        endcase
    end

    // ========================================
    // State register

    // One register holds all control and data output state.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q <= CTL_RESET;
        end
        else
        begin
            q <= n;
        end
    end

    // ========================================
    // Outputs

    // Byte enables stay all-on; this block only reads whole words.
    assign frame_n               = q.frame_n;
    assign frame_oe_n            = q.frame_oe_n;
    assign irdy_n                = q.irdy_n;
    assign irdy_oe_n             = q.irdy_oe_n;
    assign cbe_n                 = CBE_ALL_N;
    assign cbe_oe_n              = q.cbe_oe_n;
    assign local_xfer_strobe_n   = q.strobe_n;
    assign local_data_out        = q.data;
    assign burst_remaining_count = q.count;
    assign local_master_state    = q.stat;
    assign end_cause             = q.cause;

    // ========================================
    // Assertions

    // All checks run on the bus clock and stay quiet during reset.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Final phase completing in this cycle.
    sequence seq_last_done;
        done && last;
    endsequence

    // Final phase followed by its turnaround cycle.
    sequence seq_turnaround;
        seq_last_done ##1 (q.phase == PH_TURN);
    endsequence

    // Turnaround with no word left over in the read buffer.
    sequence seq_turn_empty;
        seq_turnaround ##0 (!fq.out_valid);
    endsequence

    // A word that falls through must appear unchanged next cycle.
    word_next_a: assert property (
        (done && fq.out_ready)
        |=> (q.data == $past(ad_in)) && !q.strobe_n)
        else $error("received word not on local bus next cycle");

    count_step_a: assert property (
        done |=> q.count == ($past(q.count) - BURST_ONE))
        else $error("burst count did not step down by one");

    strobe_cause_a: assert property (
        (done && !local_ready_n) |=> !q.strobe_n ##1 q.strobe_n
        || !$past(local_ready_n, 1) == 1'b1)
        else $error("transfer strobe missing after trdy and ready");

    irdy_follow_a: assert property (
        (q.phase == PH_DATA && !local_ready_n && fq.in_ready
         && !(done && last))
        |=> !q.irdy_n && !q.irdy_oe_n)
        else $error("irdy not held after local ready");

    frame_final_a: assert property (
        (q.phase == PH_DATA && last)
        |-> q.frame_n && !q.frame_oe_n && !q.irdy_oe_n)
        else $error("frame not released high on final phase");

    last_word_a: assert property (
        seq_last_done |=> (q.count == BURST_NIL)
        && (q.phase == PH_TURN))
        else $error("count not zero after final phase");

    turn_release_a: assert property (
        seq_last_done |=> q.frame_oe_n && q.cbe_oe_n
        && q.irdy_n && !q.irdy_oe_n)
        else $error("turnaround did not release frame and cbe");

    normal_end_a: assert property (
        seq_last_done |=> (q.stat == STAT_TERM)
        && (q.cause == CAUSE_NORMAL))
        else $error("no normal termination after final phase");

    idle_release_a: assert property (
        seq_turnaround |=> q.irdy_oe_n && (q.phase == PH_IDLE))
        else $error("irdy not released in idle cycle");

    count_load_a: assert property (
        (q.phase == PH_IDLE && start_req)
        |=> (q.count == $past(burst_length))
        && (q.phase == PH_DATA))
        else $error("burst count not loaded at start");

    // The buffer must have room whenever a phase completes, or a word
    // would be lost; irdy is held off one cycle ahead to ensure it.
    buf_room_a: assert property (
        done |-> fq.in_ready)
        else $error("read buffer full on a completed phase");

    // Between completions the count must not move; a start request
    // seen in mid-burst must not reload it.
    count_hold_a: assert property (
        (q.phase == PH_DATA && !done) |=> q.count == $past(q.count))
        else $error("burst count moved without a completed phase");

    // Ready seen high in a data cycle takes irdy high in the next.
    irdy_off_a: assert property (
        (q.phase == PH_DATA && local_ready_n && !(done && last))
        |=> q.irdy_n)
        else $error("irdy asserted without local ready");

    // Frame, byte enables and irdy are all driven in data phases.
    bus_driven_a: assert property (
        (q.phase == PH_DATA)
        |-> !q.frame_oe_n && !q.cbe_oe_n && !q.irdy_oe_n)
        else $error("bus lines not driven in a data phase");

    // No termination is reported while the burst is still running.
    xact_state_a: assert property (
        (q.phase == PH_DATA)
        |-> (q.stat == STAT_XACT) && (q.cause == CAUSE_NONE))
        else $error("termination reported during data phases");

    // With nothing left to hand over, the idle cycle has no strobe.
    strobe_idle_a: assert property (
        seq_turn_empty |=> q.strobe_n)
        else $error("transfer strobe still low in idle cycle");
endmodule

// File: pci_burst_pkg.sv
package pci_burst_pkg;
    // ========================================
    // Widths and depths
    localparam int DATA_W     = 32;
    localparam int BURST_W    = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int STAT_W     = 4;
    localparam int CAUSE_W    = 2;
    localparam int CBE_W      = 4;

    // ========================================
    // Encodings of the local master state and end cause
    localparam logic [STAT_W-1:0]  STAT_IDLE    = 4'h0;
    localparam logic [STAT_W-1:0]  STAT_XACT    = 4'h3;
    localparam logic [STAT_W-1:0]  STAT_TERM    = 4'h4;
    localparam logic [CAUSE_W-1:0] CAUSE_NONE   = 2'h0;
    localparam logic [CAUSE_W-1:0] CAUSE_NORMAL = 2'h1;

    // ========================================
    // Pin levels, counts and byte enables
    localparam logic               PIN_HI    = 1'h1;
    localparam logic               PIN_LO    = 1'h0;
    localparam logic               OE_DRIVE  = 1'h0;
    localparam logic               OE_FLOAT  = 1'h1;
    localparam logic [BURST_W-1:0] BURST_ONE = 8'h01;
    localparam logic [BURST_W-1:0] BURST_NIL = 8'h00;
    localparam logic [CBE_W-1:0]   CBE_ALL_N = 4'h0;
    localparam logic [DATA_W-1:0]  DATA_NIL  = 32'h0;

    // Phases of the closing part of a burst read.
    typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_TURN} phase_t;
endpackage

// File: word_fifo_if.sv
`timescale 1ns/10ps
// ========================================
// Valid/ready word channel around the read buffer
interface word_fifo_if #(parameter int W = 32);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fill  (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data);
    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
endinterface

// File: word_fifo.sv
`timescale 1ns/10ps
// ========================================
// Read buffer with fall-through when empty
module word_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
)(
    input wire logic   clk,
    input wire logic   rst,
    word_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t n;
    logic        empty;
    logic        full;
    logic        push;
    logic        pop;

    // An empty buffer passes the word straight through, so a ready
    // consumer sees no extra latency.
    assign empty = q.wp == q.rp;
    assign full  = (q.wp[AW] != q.rp[AW])
                && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign f.in_ready  = !full;
    assign f.out_valid = !empty || f.in_valid;
    assign f.out_data  = empty ? f.in_data : q.mem[q.rp[AW-1:0]];
    assign push = f.in_valid && !full && !(empty && f.out_ready);
    assign pop  = !empty && f.out_ready;

    // Next state: store on push, advance read pointer on pop.
    always_comb
    begin
        n = q;
        if (push)
        begin
            n.mem[q.wp[AW-1:0]] = f.in_data;
            n.wp = q.wp + 1'b1;
        end
        if (pop)
        begin
            n.rp = q.rp + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end
endmodule

// File: pci_target_model.sv
`timescale 1ns/10ps
// ========================================
// Bus target: answers each data phase with a counted word.
module pci_target_model
    import pci_burst_pkg::*;
#(
    parameter logic [DATA_W-1:0] BASE = 32'hC0DE_0100
)(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              frame_oe_n,
    input  wire logic              irdy_n,
    input  wire logic              stall,
    output logic                   trdy_n,
    output logic [DATA_W-1:0]      ad_in
);
    logic [DATA_W-1:0] idx_q;

    // Ready only while frame is driven; the pull-up wins afterwards.
    assign trdy_n = (frame_oe_n == OE_DRIVE && !stall)
                  ? PIN_LO : PIN_HI;
    // Released lines show the inverse, so a stale word never passes.
    assign ad_in = (trdy_n == PIN_LO)
                 ? BASE + idx_q : ~(BASE + idx_q);

    // Step to the next word on each completed phase.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            idx_q <= DATA_NIL;
        else if (frame_oe_n == OE_FLOAT)
            idx_q <= DATA_NIL;
        else if (irdy_n == PIN_LO && trdy_n == PIN_LO)
            idx_q <= idx_q + 32'h1;
    end
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pci_burst_pkg::*;
    localparam logic [DATA_W-1:0] BASE = 32'hC0DE_0100;
    logic               mclk, sys_rst, start_req, trdy_n, stall;
    logic               local_ready_n, rdy_prev, frame_n, frame_oe_n;
    logic               irdy_n, irdy_oe_n, cbe_oe_n, local_xfer_strobe_n;
    logic [BURST_W-1:0] burst_length, burst_remaining_count;
    logic [DATA_W-1:0]  ad_in, local_data_out;
    logic [CBE_W-1:0]   cbe_n;
    logic [STAT_W-1:0]  local_master_state;
    logic [CAUSE_W-1:0] end_cause;
    logic [DATA_W-1:0]  got[$];
    int                 err_total = 0;
    int                 num_checks = 0;

    pci_master_burst_read_completion dut (
        .mclk(mclk), .sys_rst(sys_rst), .start_req(start_req),
        .burst_length(burst_length), .ad_in(ad_in), .trdy_n(trdy_n),
        .local_ready_n(local_ready_n), .frame_n(frame_n),
        .frame_oe_n(frame_oe_n), .irdy_n(irdy_n), .irdy_oe_n(irdy_oe_n),
        .cbe_n(cbe_n), .cbe_oe_n(cbe_oe_n),
        .local_xfer_strobe_n(local_xfer_strobe_n),
        .local_data_out(local_data_out),
        .burst_remaining_count(burst_remaining_count),
        .local_master_state(local_master_state), .end_cause(end_cause));

    pci_target_model #(.BASE(BASE)) target (
        .mclk(mclk), .sys_rst(sys_rst), .frame_oe_n(frame_oe_n),
        .irdy_n(irdy_n), .stall(stall), .trdy_n(trdy_n), .ad_in(ad_in));

    // Free-running clock, 20 ns period.
    always #10 mclk = ~mclk;

    // ========================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Collect words and watch the local handshake; values are pre-edge.
    always @(posedge mclk)
    begin
        if (!sys_rst)
        begin
            if (local_xfer_strobe_n === PIN_LO)
            begin
                got.push_back(local_data_out);
                check(rdy_prev, PIN_LO);
            end
            if (irdy_oe_n === OE_DRIVE && frame_oe_n === OE_DRIVE)
                check(irdy_n, rdy_prev);
        end
        rdy_prev = local_ready_n;
    end

    // ========================================
    // Shared burst steps
    task automatic start_burst(input logic [BURST_W-1:0] len);
        @(posedge mclk);
        local_ready_n <= PIN_LO;
        got.delete();
        @(posedge mclk);
        start_req <= PIN_HI;
        burst_length <= len;
        @(posedge mclk);
        start_req <= PIN_LO;
    endtask

    // Bounded wait for the idle cycle, then judge the delivered words.
    task automatic finish_burst(input int len, input string name);
        int n;
        for (n = 0; n < 100; n++)
        begin
            @(negedge mclk);
            if (irdy_oe_n === OE_FLOAT && local_master_state === STAT_TERM)
                break;
        end
        if (n == 100)
        begin
            check(n, 0);
            results();
        end
        @(posedge mclk);
        local_ready_n <= PIN_HI;
        repeat (2) @(posedge mclk);
        check(got.size(), len);
        for (int i = 0; i < got.size(); i++)
            check(got[i], BASE + i);
        check(burst_remaining_count, BURST_NIL);
        check(end_cause, CAUSE_NORMAL);
        $display("test %s done", name);
    endtask

    // ========================================
    // Scenarios
    task automatic t_walk;
        start_burst(8'h03);
        @(negedge mclk);
        check(burst_remaining_count, 8'h03);
        check(irdy_n, PIN_LO);
        check(cbe_n, CBE_ALL_N);
        check(local_master_state, STAT_XACT);
        @(negedge mclk);
        check(local_data_out, BASE);
        check(local_xfer_strobe_n, PIN_LO);
        check(burst_remaining_count, 8'h02);
        @(negedge mclk);
        check({frame_n, irdy_n}, {PIN_HI, PIN_LO});
        check(local_data_out, BASE + 32'h1);
        @(negedge mclk);
        check({frame_oe_n, cbe_oe_n, irdy_n}, 3'h7);
        check(local_master_state, STAT_TERM);
        check(local_data_out, BASE + 32'h2);
        check(burst_remaining_count, BURST_NIL);
        check(local_xfer_strobe_n, PIN_LO);
        @(negedge mclk);
        check({irdy_oe_n, local_xfer_strobe_n}, 2'h3);
        finish_burst(3, "walk");
    endtask

    // A one-word burst is final from its first phase.
    task automatic t_single;
        start_burst(BURST_ONE);
        @(negedge mclk);
        check({frame_n, irdy_n}, {PIN_HI, PIN_LO});
        @(negedge mclk);
        check(local_data_out, BASE);
        check(local_master_state, STAT_TERM);
        finish_burst(1, "single");
    endtask

    // Target wait states; a start in mid-burst must be ignored.
    task automatic t_target_wait;
        start_burst(8'h04);
        @(posedge mclk);
        stall <= 1'h1;
        start_req <= PIN_HI;
        burst_length <= 8'h09;
        @(posedge mclk);
        start_req <= PIN_LO;
        @(posedge mclk);
        stall <= 1'h0;
        finish_burst(4, "target_wait");
    endtask

    // Local master stalls; irdy must follow its ready.
    task automatic t_local_stall;
        start_burst(8'h06);
        @(posedge mclk);
        local_ready_n <= PIN_HI;
        repeat (4) @(posedge mclk);
        local_ready_n <= PIN_LO;
        finish_burst(6, "local_stall");
    endtask

    // Reset, then the scenarios, then the verdict.
    initial
    begin
        mclk = 1'h0;
        sys_rst = 1'h1;
        start_req = PIN_LO;
        burst_length = BURST_ONE;
        local_ready_n = PIN_HI;
        stall = 1'h0;
        repeat (10) @(posedge mclk);
        check({frame_oe_n, irdy_oe_n, local_xfer_strobe_n}, 3'h7);
        check(local_master_state, STAT_IDLE);
        sys_rst <= 1'h0;
        t_walk();
        t_single();
        t_target_wait();
        t_local_stall();
        results();
    end
endmodule
